// ==== core/ext_osc_pkg.sv ====
// Purpose: Shared constants and types for the external oscillator control
// Assumes: Register sits in the special-function register space, 8-bit data
// Notes:   Mode encodings follow the 3-bit mode select field
package ext_osc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] EXT_OSC_CTRL_ADDR = 8'hB1;
    localparam logic [7:0] EXT_OSC_CTRL_RESET = 8'h00;
    localparam int FLAG_BIT = 7;
    localparam int MODE_MSB = 6;
    localparam int MODE_LSB = 4;
    localparam int UNUSED_BIT = 3;
    localparam int DRIVE_MSB = 2;
    localparam int DRIVE_LSB = 0;
    localparam logic [2:0] DRIVE_RESET = 3'h0;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // Mode encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF_A = 3'b000,
        MODE_OFF_B = 3'b001,
        MODE_CMOS = 3'b010,
        MODE_CMOS_DIV2 = 3'b011,
        MODE_RC = 3'b100,
        MODE_CAP = 3'b101,
        MODE_XTAL = 3'b110,
        MODE_XTAL_DIV2 = 3'b111
    } osc_mode_type;

    localparam osc_mode_type MODE_RESET = MODE_OFF_A;

    // Crystal modes match 11x
    function automatic logic is_crystal(input osc_mode_type m);
        is_crystal = (m[2:1] == 2'b11);
    endfunction : is_crystal

    // Circuit is off for 00x
    function automatic logic is_off(input osc_mode_type m);
        is_off = (m[2:1] == 2'b00);
    endfunction : is_off

endpackage : ext_osc_pkg

// ==== core/osc_status_if.sv ====
// Purpose: Carries crystal mode and stable status between control and sync
// Assumes: Single clock domain on both sides
// Notes:   Control side drives crystal_on, sync side returns stable
`timescale 1ns/100ps
interface osc_status_if;
    logic crystal_on;
    logic stable;
    modport ctrl (output crystal_on, input stable);
    modport sync (input crystal_on, output stable);
endinterface : osc_status_if

// ==== core/osc_stable_sync.sv ====
// Purpose: Brings the amplitude detector level into the system clock domain
// Assumes: amp_ok_in is asynchronous to clk_in
// Notes:   Flag is forced low from one clock after crystal mode is left
`timescale 1ns/100ps
module osc_stable_sync
    import ext_osc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Detector level
    input wire logic amp_ok_in,
    // Status carrier
    osc_status_if.sync st
);

    logic [SYNC_STAGES-1:0] sync_ff;
    logic stable_ff;

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= {sync_ff[SYNC_STAGES-2:0], amp_ok_in};
        end
    end

    // ----------------------------------------------------------------
    // Qualified stable flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stable_ff <= 1'b0;
        end else begin
            stable_ff <= sync_ff[SYNC_STAGES-1] & st.crystal_on;
        end
    end

    assign st.stable = stable_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_flag_sync_delay: assert property ($rose(st.stable) |->
        $past(amp_ok_in, 3) && $past(st.crystal_on))
        else $error("Stable flag rose without synchronised detector level");

    a_flag_off_mode: assert property (!st.crystal_on |=> !st.stable)
        else $error("Stable flag set outside crystal mode");

endmodule : osc_stable_sync

// ==== core/ext_osc_ctrl.sv ====
// Purpose: External oscillator control register and drive circuit selects
// Assumes: Core reaches the register over the special-function register port
// Notes:   Analog oscillator cells sit outside and follow the select outputs
`timescale 1ns/100ps
module ext_osc_ctrl
    import ext_osc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Special-function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Amplitude detector from the analog cell
    input wire logic amp_ok_in,
    // Drive circuit controls
    output logic osc_enable_out,
    output logic cmos_sel_out,
    output logic rc_sel_out,
    output logic cap_sel_out,
    output logic crystal_sel_out,
    output logic div2_sel_out,
    output logic [2:0] ext_osc_drive_ctrl_out
);

    osc_mode_type ext_osc_mode_sel_ff;
    logic [2:0] ext_osc_drive_ctrl_ff;
    logic [7:0] rdata_ff;
    logic osc_enable_ff;
    logic cmos_sel_ff;
    logic rc_sel_ff;
    logic cap_sel_ff;
    logic crystal_sel_ff;
    logic div2_sel_ff;
    logic crystal_stable_flag;
    logic reg_hit;

    osc_status_if st ();

    assign reg_hit = (sfr_addr_in == EXT_OSC_CTRL_ADDR);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ext_osc_mode_sel_ff <= MODE_RESET;
            ext_osc_drive_ctrl_ff <= DRIVE_RESET;
        end else if (sfr_wr_in && reg_hit) begin
            // Bit 7 and bit 3 have no storage
            ext_osc_mode_sel_ff <= osc_mode_type'(sfr_wdata_in[MODE_MSB:MODE_LSB]);
            ext_osc_drive_ctrl_ff <= sfr_wdata_in[DRIVE_MSB:DRIVE_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= EXT_OSC_CTRL_RESET;
        end else if (sfr_rd_in && reg_hit) begin
            rdata_ff <= {crystal_stable_flag, ext_osc_mode_sel_ff,
                         1'b0, ext_osc_drive_ctrl_ff};
        end else if (sfr_rd_in) begin
            rdata_ff <= 8'h00;
        end
    end

    assign sfr_rdata_out = rdata_ff;

    // ----------------------------------------------------------------
    // Stable flag path
    // ----------------------------------------------------------------
    assign st.crystal_on = is_crystal(ext_osc_mode_sel_ff);
    assign crystal_stable_flag = st.stable & st.crystal_on;

    osc_stable_sync u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .amp_ok_in(amp_ok_in),
        .st(st.sync)
    );

    // ----------------------------------------------------------------
    // Mode decode to drive circuit
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            osc_enable_ff <= 1'b0;
            cmos_sel_ff <= 1'b0;
            rc_sel_ff <= 1'b0;
            cap_sel_ff <= 1'b0;
            crystal_sel_ff <= 1'b0;
            div2_sel_ff <= 1'b0;
        end else begin
            osc_enable_ff <= !is_off(ext_osc_mode_sel_ff);
            cmos_sel_ff <= 1'b0;
            rc_sel_ff <= 1'b0;
            cap_sel_ff <= 1'b0;
            crystal_sel_ff <= 1'b0;
            div2_sel_ff <= 1'b0;
            case (ext_osc_mode_sel_ff)
                MODE_OFF_A, MODE_OFF_B: begin
                end
                MODE_CMOS: begin
                    cmos_sel_ff <= 1'b1;
                end
                MODE_CMOS_DIV2: begin
                    cmos_sel_ff <= 1'b1;
                    div2_sel_ff <= 1'b1;
                end
                MODE_RC: begin
                    rc_sel_ff <= 1'b1;
                end
                MODE_CAP: begin
                    cap_sel_ff <= 1'b1;
                end
                MODE_XTAL: begin
                    crystal_sel_ff <= 1'b1;
                end
                MODE_XTAL_DIV2: begin
                    crystal_sel_ff <= 1'b1;
                    div2_sel_ff <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Drive field passes through one register stage to the amplifier bias
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ext_osc_drive_ctrl_out <= DRIVE_RESET;
        end else begin
            ext_osc_drive_ctrl_out <= ext_osc_drive_ctrl_ff;
        end
    end

    assign osc_enable_out = osc_enable_ff;
    assign cmos_sel_out = cmos_sel_ff;
    assign rc_sel_out = rc_sel_ff;
    assign cap_sel_out = cap_sel_ff;
    assign crystal_sel_out = crystal_sel_ff;
    assign div2_sel_out = div2_sel_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence wr_ctrl_seq;
        sfr_wr_in && reg_hit;
    endsequence

    sequence rd_ctrl_seq;
        !sfr_wr_in && sfr_rd_in && reg_hit;
    endsequence

    a_mode_off: assert property (
        wr_ctrl_seq ##0 (sfr_wdata_in[MODE_MSB:MODE_MSB-1] == 2'b00) ##1 !sfr_wr_in
        |=> !osc_enable_out && !crystal_sel_out && !cmos_sel_out)
        else $error("Oscillator enabled in an off mode");

    a_xtal_div2: assert property (
        wr_ctrl_seq ##0 (sfr_wdata_in[MODE_MSB:MODE_LSB] == 3'b111) ##1 !sfr_wr_in
        |=> osc_enable_out && crystal_sel_out && div2_sel_out && !rc_sel_out)
        else $error("Crystal divide-by-2 mode not driven");

    a_mode_decode: assert property (
        $past(ext_osc_mode_sel_ff) == MODE_RC |-> rc_sel_out && !cap_sel_out
            && !crystal_sel_out && !cmos_sel_out && !div2_sel_out)
        else $error("RC mode decode wrong");

    a_cap_decode: assert property (
        $past(ext_osc_mode_sel_ff) == MODE_CAP |-> cap_sel_out && !rc_sel_out
            && !div2_sel_out)
        else $error("Capacitor mode decode wrong");

    a_unused_zero: assert property (
        rd_ctrl_seq |=> sfr_rdata_out[UNUSED_BIT] == 1'b0
            && sfr_rdata_out[MODE_MSB:MODE_LSB] == $past(ext_osc_mode_sel_ff))
        else $error("Read data mismatch on mode or unused bit");

    a_flag_readback: assert property (
        rd_ctrl_seq ##0 !st.crystal_on |=> !sfr_rdata_out[FLAG_BIT])
        else $error("Stable flag read as set outside crystal mode");

    a_flag_mode_exit: assert property (
        wr_ctrl_seq ##0 (sfr_wdata_in[MODE_MSB:MODE_MSB-1] != 2'b11) ##1 rd_ctrl_seq
        |=> !sfr_rdata_out[FLAG_BIT])
        else $error("Stable flag read as set just after leaving crystal mode");

    a_xtal_plain: assert property (
        $past(ext_osc_mode_sel_ff) == MODE_XTAL |-> crystal_sel_out && osc_enable_out
            && !div2_sel_out && !rc_sel_out && !cap_sel_out && !cmos_sel_out)
        else $error("Crystal mode decode wrong");

    a_cmos_plain: assert property (
        $past(ext_osc_mode_sel_ff) == MODE_CMOS |-> cmos_sel_out && osc_enable_out
            && !div2_sel_out && !crystal_sel_out && !rc_sel_out && !cap_sel_out)
        else $error("CMOS clock mode decode wrong");

    a_cmos_div2: assert property (
        $past(ext_osc_mode_sel_ff) == MODE_CMOS_DIV2 |-> cmos_sel_out && div2_sel_out
            && osc_enable_out && !crystal_sel_out && !rc_sel_out && !cap_sel_out)
        else $error("CMOS clock divide-by-2 mode decode wrong");

endmodule : ext_osc_ctrl

// ==== sim/osc_crystal_model.sv ====
// Purpose: Behavioural crystal cell with amplitude detector
// Assumes: Detector settles a fixed count after the crystal cell is enabled
// Notes:   Detector drops on the next clock edge when the cell is disabled or leaves crystal mode
`timescale 1ns/100ps
module osc_crystal_model #(
    parameter int SETTLE = 40
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Drive circuit selects
    input wire logic osc_enable_in,
    input wire logic crystal_sel_in,
    // Detector level
    output logic amp_ok_out
);
    int settle_cnt_ff;

    // ----------------------------------------------------------------
    // Settling counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !(osc_enable_in && crystal_sel_in)) begin
            settle_cnt_ff <= 0;
        end else if (settle_cnt_ff < SETTLE) begin
            settle_cnt_ff <= settle_cnt_ff + 1;
        end
    end

    // Stable only once settled while running in crystal mode
    assign amp_ok_out = (settle_cnt_ff >= SETTLE);
endmodule : osc_crystal_model

// ==== sim/test_external_oscillator_control.sv ====
// Purpose: Self-checking bench for the external oscillator control register
// Assumes: Strobe register port, crystal model on the detector input
// Notes:   Drive codes are swept across all modes in one loop
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, 8'(e), 8'(g))
module test_external_oscillator_control;
    import ext_osc_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out;
    logic amp_ok_in;
    logic osc_enable_out, cmos_sel_out, rc_sel_out, cap_sel_out;
    logic crystal_sel_out, div2_sel_out;
    logic [2:0] ext_osc_drive_ctrl_out;
    logic [7:0] rd_val, sel_val;
    int err_total = 0;
    int n_checks = 0;

    always #25 clk_in = ~clk_in;

    ext_osc_ctrl i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_rdata_out(sfr_rdata_out), .amp_ok_in(amp_ok_in), .osc_enable_out(osc_enable_out),
        .cmos_sel_out(cmos_sel_out), .rc_sel_out(rc_sel_out), .cap_sel_out(cap_sel_out),
        .crystal_sel_out(crystal_sel_out), .div2_sel_out(div2_sel_out),
        .ext_osc_drive_ctrl_out(ext_osc_drive_ctrl_out));
    osc_crystal_model #(.SETTLE(40)) i_xtal (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .osc_enable_in(osc_enable_out), .crystal_sel_in(crystal_sel_out), .amp_ok_out(amp_ok_in));

    assign sel_val = {2'b00, osc_enable_out, cmos_sel_out, rc_sel_out, cap_sel_out,
        crystal_sel_out, div2_sel_out};

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : check

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= addr;
        sfr_wdata_in <= data;
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        sfr_rd_in <= 1'b1;
        sfr_addr_in <= addr;
        @(posedge clk_in);
        sfr_rd_in <= 1'b0;
        @(negedge clk_in);
        data = sfr_rdata_out;
    endtask : sfr_read

    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [2:0] m;
        logic [7:0] exp_sel;
        int polls;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        `CHK("reset selects", 8'h00, sel_val);
        sfr_read(EXT_OSC_CTRL_ADDR, rd_val);
        `CHK("reset value", EXT_OSC_CTRL_RESET, rd_val);
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            sfr_write(EXT_OSC_CTRL_ADDR, {1'b1, m, 1'b1, ~m});
            exp_sel = {2'b00, m[2:1] != 2'b00, m[2:1] == 2'b01, m == 3'b100, m == 3'b101,
                m[2:1] == 2'b11, m[0] && m[2:1] != 2'b00 && m != 3'b101};
            `CHK("mode selects", exp_sel, sel_val);
            `CHK("drive out", 3'(~m), ext_osc_drive_ctrl_out);
            sfr_read(EXT_OSC_CTRL_ADDR, rd_val);
            `CHK("mode readback", {1'b0, m, 1'b0, ~m}, rd_val);
        end
        sfr_write(8'hB2, 8'h00);
        sfr_read(EXT_OSC_CTRL_ADDR, rd_val);
        `CHK("foreign write", 8'h70, rd_val);
        sfr_read(8'hB2, rd_val);
        `CHK("foreign read", 8'h00, rd_val);
        sfr_write(EXT_OSC_CTRL_ADDR, 8'h67);
        repeat (20000) @(posedge clk_in);
        polls = 0;
        do begin
            sfr_read(EXT_OSC_CTRL_ADDR, rd_val);
            polls++;
        end while (rd_val[FLAG_BIT] !== 1'b1 && polls < 50);
        if (polls >= 50) begin
            err_total++;
            conclude();
        end
        `CHK("crystal stable", 8'hE7, rd_val);
        `CHK("selects before switch", 8'h22, sel_val);
        sfr_write(EXT_OSC_CTRL_ADDR, 8'h60);
        sfr_read(EXT_OSC_CTRL_ADDR, rd_val);
        `CHK("low power drive", 8'hE0, rd_val);
        `CHK("low drive out", 8'h00, ext_osc_drive_ctrl_out);
        @(posedge clk_in);
        sfr_rd_in <= 1'b1;
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= EXT_OSC_CTRL_ADDR;
        sfr_wdata_in <= 8'h42;
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
        @(negedge clk_in);
        `CHK("read beside write", 8'hE0, sfr_rdata_out);
        @(posedge clk_in);
        sfr_rd_in <= 1'b0;
        @(negedge clk_in);
        `CHK("read after mode exit", 8'h42, sfr_rdata_out);
        sfr_read(EXT_OSC_CTRL_ADDR, rd_val);
        `CHK("flag outside crystal", 8'h42, rd_val);
        `CHK("rc selects", 8'h28, sel_val);
        conclude();
    end
endmodule : test_external_oscillator_control
